// file: hw/pcelc_pkg.sv
// Shared constants for the endianness, link reservation and PC sequencing core
package pcelc_pkg;

	// ==========================================================
	// Register bus map (byte addresses, one word each)
	localparam int          ADDR_W       = 4;
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATE    = 4'h4;
	localparam logic [3:0]  REG_PC       = 4'h8;

	// CTRL fields
	localparam int          CTRL_RE_BIT  = 0;
	localparam logic        CTRL_RE_RST  = 1'b0;

	// STATE fields (read only)
	localparam int          ST_MEM_BE    = 0;
	localparam int          ST_LS_BE     = 1;
	localparam int          ST_SWAP      = 2;
	localparam int          ST_LLF       = 3;
	localparam int          ST_ISA       = 4;
	localparam int          ST_SC_OK     = 5;

	// ==========================================================
	// Sequencing constants
	localparam logic [31:0] PC_RESET     = 32'h0000_0000;
	localparam logic [31:0] INC_COMPACT  = 32'h0000_0002;
	localparam logic [31:0] INC_WORD     = 32'h0000_0004;
	localparam logic [31:0] LINK_COMPACT = 32'h0000_0004;
	localparam logic [31:0] LINK_WORD    = 32'h0000_0008;
	localparam logic [4:0]  LINK_GPR     = 5'h1F;
	localparam logic        ISA_WORD     = 1'b0;
	localparam logic        ISA_COMPACT  = 1'b1;

	// Endianness encoding of the strap
	localparam logic        END_LITTLE   = 1'b0;
	localparam logic        END_BIG      = 1'b1;
	// Edges after reset release before the synchronised strap is valid
	localparam logic [1:0]  STRAP_SETTLE = 2'h2;

	// Compact register number translation
	localparam logic [2:0]  CREG_R0      = 3'h0;
	localparam logic [2:0]  CREG_R1      = 3'h1;
	localparam logic [4:0]  XLAT_R0      = 5'h10;
	localparam logic [4:0]  XLAT_R1      = 5'h11;

endpackage : pcelc_pkg

// file: hw/pcelc_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
module pcelc_sync (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Level in and out
	input  wire logic din,
	output logic      dout
);

	logic meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			dout   <= 1'b0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end

endmodule : pcelc_sync

// file: hw/pcelc_xlat.sv
// Registered translation of compact register numbers to full register numbers
`timescale 1ns/1ps
module pcelc_xlat
	import pcelc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	// Compact number in, full number out
	input  wire logic [2:0] creg,
	output logic      [4:0] gpr_q
);

	// Registers 0 and 1 of the compact set map to 16 and 17
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			gpr_q <= 5'h00;
		end else begin
			unique case (creg)
				CREG_R0: gpr_q <= XLAT_R0;
				CREG_R1: gpr_q <= XLAT_R1;
				default: gpr_q <= {2'b00, creg};
			endcase
		end
	end

endmodule : pcelc_xlat

// file: hw/pcelc_core.sv
// Endianness selection, link reservation flag and program counter sequencing
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Latch memory endianness strap at reset
// - Memory and kernel use latched endianness
// - Load/store endianness is strap XOR swap
// - Swap only with RE bit in user
// - Load-linked sets reservation flag
// - Conditional store outcome follows reservation flag
// - Conflicting activity clears reservation flag
// - Exception return clears reservation flag
// - PC holds instruction address through slot
// - PC advances 2 compact, else 4
// - Taken branch target loads in delay slot
// - Delayed result writes with next instruction
// - Own steps ordered; cross-instruction order undefined
// - Full 32-bit PC, all bits significant
// - Restart address to GPR or exception register
// - Map compact register numbers to full ones
// - One-bit instruction set selector kept
module pcelc_core
	import pcelc_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	// Endianness strap pin
	input  wire logic              endian_strap_pin,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// Pipeline slot strobe and attributes
	input  wire logic              slot_valid,
	input  wire logic              slot_compact,
	input  wire logic              slot_user_mode,
	input  wire logic              slot_branch_taken,
	input  wire logic [31:0]       slot_target,
	input  wire logic              slot_link,
	input  wire logic              slot_load_linked,
	input  wire logic              slot_store_cond,
	input  wire logic              slot_eret,
	input  wire logic              slot_exception,
	input  wire logic [31:0]       slot_exc_vector,
	input  wire logic              slot_late_wr,
	input  wire logic [4:0]        slot_late_idx,
	input  wire logic [31:0]       slot_late_data,
	input  wire logic [2:0]        slot_compact_reg,
	input  wire logic              atomic_conflict,
	// Core state
	output logic      [31:0]       pc_q,
	output logic                   instruction_set_select_q,
	output logic                   memory_big_endian_cfg_q,
	output logic                   user_endian_swap_q,
	output logic                   load_store_big_endian_q,
	output logic                   link_reservation_flag_q,
	// Conditional store answer
	output logic                   sc_done_q,
	output logic                   sc_success_q,
	// Register write ports
	output logic                   link_wr_en_q,
	output logic      [4:0]        link_wr_idx_q,
	output logic      [31:0]       link_wr_data_q,
	output logic                   epc_wr_en_q,
	output logic      [31:0]       epc_wr_data_q,
	output logic                   late_wr_en_q,
	output logic      [4:0]        late_wr_idx_q,
	output logic      [31:0]       late_wr_data_q,
	output logic      [4:0]        compact_gpr_idx_q
);

	// ==========================================================
	// Internal state
	logic        strap_s;
	logic [1:0]  strap_cnt_q;
	logic        strap_done_q;
	logic        ctrl_re_q;
	logic        swap_d;
	logic        ls_be_d;
	logic        pend_q;
	logic [31:0] pend_target_q;
	logic        pend_isa_q;
	logic        held_q;
	logic [4:0]  held_idx_q;
	logic [31:0] held_data_q;
	logic [31:0] pc_inc;
	logic [31:0] link_sum;
	logic        bus_req;
	logic [31:0] state_word;

	// ==========================================================
	// Strap capture
	pcelc_sync u_strap_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.din     (endian_strap_pin),
		.dout    (strap_s)
	);

	// Take the strap once, after the synchroniser has filled
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strap_cnt_q             <= 2'h0;
			strap_done_q            <= 1'b0;
			memory_big_endian_cfg_q <= END_LITTLE;
		end else if (!strap_done_q) begin
			if (strap_cnt_q == STRAP_SETTLE) begin
				memory_big_endian_cfg_q <= strap_s;
				strap_done_q            <= 1'b1;
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

	// ==========================================================
	// Endianness for loads and stores, in step with the strap capture edge
	always_comb begin
		swap_d  = ctrl_re_q & slot_user_mode;
		ls_be_d = ((!strap_done_q && strap_cnt_q == STRAP_SETTLE) ? strap_s : memory_big_endian_cfg_q) ^ swap_d;
	end

	// Swap and load/store endianness move on the same edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			user_endian_swap_q      <= 1'b0;
			load_store_big_endian_q <= END_LITTLE;
		end else begin
			user_endian_swap_q      <= swap_d;
			load_store_big_endian_q <= ls_be_d;
		end
	end

	// ==========================================================
	// Link reservation flag
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			link_reservation_flag_q <= 1'b0;
		end else if (slot_valid && slot_load_linked) begin
			link_reservation_flag_q <= 1'b1;
		end else if (atomic_conflict) begin
			link_reservation_flag_q <= 1'b0;
		end else if (slot_valid && (slot_eret || slot_store_cond)) begin
			link_reservation_flag_q <= 1'b0;
		end
	end

	// Conditional store reads the flag as it stood in its slot
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sc_done_q    <= 1'b0;
			sc_success_q <= 1'b0;
		end else begin
			sc_done_q <= slot_valid && slot_store_cond;
			if (slot_valid && slot_store_cond) begin
				sc_success_q <= link_reservation_flag_q;
			end
		end
	end

	// ==========================================================
	// Program counter sequencing
	always_comb begin
		pc_inc   = slot_compact ? INC_COMPACT : INC_WORD;
		link_sum = pc_q + (slot_compact ? LINK_COMPACT : LINK_WORD);
	end

	// PC only moves at a slot boundary, so it names the current slot
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pc_q                     <= PC_RESET;
			instruction_set_select_q <= ISA_WORD;
			pend_q                   <= 1'b0;
			pend_target_q            <= PC_RESET;
			pend_isa_q               <= ISA_WORD;
		end else if (slot_valid) begin
			if (slot_exception) begin
				pc_q                     <= slot_exc_vector;
				instruction_set_select_q <= ISA_WORD;
				pend_q                   <= 1'b0;
			end else begin
				if (pend_q) begin
					pc_q                     <= pend_target_q;
					instruction_set_select_q <= pend_isa_q;
				end else begin
					pc_q <= pc_q + pc_inc;
				end
				pend_q <= slot_branch_taken;
				if (slot_branch_taken) begin
					pend_target_q <= {slot_target[31:1], 1'b0};
					pend_isa_q    <= slot_target[0];
				end
			end
		end
	end

	// Restart address, with the selector in bit 0
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			link_wr_en_q   <= 1'b0;
			link_wr_idx_q  <= LINK_GPR;
			link_wr_data_q <= 32'h0000_0000;
			epc_wr_en_q    <= 1'b0;
			epc_wr_data_q  <= 32'h0000_0000;
		end else begin
			link_wr_en_q <= slot_valid && slot_link && !slot_exception;
			epc_wr_en_q  <= slot_valid && slot_exception;
			if (slot_valid && slot_link) begin
				link_wr_data_q <= {link_sum[31:1], instruction_set_select_q};
			end
			if (slot_valid && slot_exception) begin
				epc_wr_data_q <= {pc_q[31:1], instruction_set_select_q};
			end
		end
	end

	// ==========================================================
	// Delayed result writes
	// A late result is held and issued with the next slot's effects;
	// no order is promised against that slot's own link write.
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			held_q         <= 1'b0;
			held_idx_q     <= 5'h00;
			held_data_q    <= 32'h0000_0000;
			late_wr_en_q   <= 1'b0;
			late_wr_idx_q  <= 5'h00;
			late_wr_data_q <= 32'h0000_0000;
		end else begin
			late_wr_en_q <= slot_valid && held_q;
			if (slot_valid) begin
				held_q <= slot_late_wr;
				if (held_q) begin
					late_wr_idx_q  <= held_idx_q;
					late_wr_data_q <= held_data_q;
				end
				if (slot_late_wr) begin
					held_idx_q  <= slot_late_idx;
					held_data_q <= slot_late_data;
				end
			end
		end
	end

	// Compact register number translation
	pcelc_xlat u_xlat (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.creg    (slot_compact_reg),
		.gpr_q   (compact_gpr_idx_q)
	);

	// ==========================================================
	// Avalon-MM slave: one wait cycle, then the answer
	assign bus_req = avs_read || avs_write;

	always_comb begin
		state_word              = 32'h0000_0000;
		state_word[ST_MEM_BE]   = memory_big_endian_cfg_q;
		state_word[ST_LS_BE]    = load_store_big_endian_q;
		state_word[ST_SWAP]     = user_endian_swap_q;
		state_word[ST_LLF]      = link_reservation_flag_q;
		state_word[ST_ISA]      = instruction_set_select_q;
		state_word[ST_SC_OK]    = sc_success_q;
	end

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !(bus_req && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				unique case (avs_address)
					REG_CTRL:  avs_readdata <= {31'h0, ctrl_re_q};
					REG_STATE: avs_readdata <= state_word;
					REG_PC:    avs_readdata <= pc_q;
					default:   avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register write at the accepting edge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl_re_q <= CTRL_RE_RST;
		end else if (avs_write && !avs_waitrequest && avs_address == REG_CTRL) begin
			ctrl_re_q <= avs_writedata[CTRL_RE_BIT];
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_ls_endian_xor: assert property (
		load_store_big_endian_q == (memory_big_endian_cfg_q ^ user_endian_swap_q))
		else $error("load/store endianness not strap xor swap");

	a_swap_user_only: assert property (
		user_endian_swap_q |-> $past(slot_user_mode) && $past(ctrl_re_q))
		else $error("endian swap outside user mode or without RE");

	a_mem_endian_fixed: assert property (
		strap_done_q |=> $stable(memory_big_endian_cfg_q))
		else $error("memory endianness changed after capture");

	a_strap_capture: assert property (
		$rose(strap_done_q) |-> memory_big_endian_cfg_q == $past(strap_s))
		else $error("strap not captured");

	a_llf_set: assert property (
		slot_valid && slot_load_linked |=> link_reservation_flag_q)
		else $error("load-linked did not set flag");

	a_sc_outcome: assert property (
		slot_valid && slot_store_cond |=> sc_done_q && sc_success_q == $past(link_reservation_flag_q))
		else $error("store-conditional outcome wrong");

	a_llf_conflict_clr: assert property (
		atomic_conflict && !(slot_valid && slot_load_linked) |=> !link_reservation_flag_q)
		else $error("conflict did not clear flag");

	a_llf_eret_clr: assert property (
		slot_valid && slot_eret && !slot_load_linked |=> !link_reservation_flag_q)
		else $error("exception return did not clear flag");

	a_pc_hold_slot: assert property (
		!slot_valid |=> $stable(pc_q))
		else $error("pc moved without a slot");

	a_pc_increment: assert property (
		slot_valid && !pend_q && !slot_exception |=> pc_q == $past(pc_q) + $past(pc_inc))
		else $error("pc increment wrong");

	a_branch_delay: assert property (
		slot_valid && pend_q && !slot_exception |=> pc_q == $past(pend_target_q))
		else $error("branch target not taken in delay slot");

	a_late_write: assert property (
		slot_valid && held_q |=> late_wr_en_q && late_wr_data_q == $past(held_data_q))
		else $error("late write not issued with next slot");

	a_late_hold: assert property (
		slot_valid && slot_late_wr |=> held_q && held_data_q == $past(slot_late_data))
		else $error("late result not held for next slot");

	a_bus_ack: assert property (
		bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not one wait cycle");

	c_ll_sc_ok: cover property (sc_done_q && sc_success_q);
	c_branch: cover property (slot_valid && pend_q && !slot_exception);
	c_late: cover property (late_wr_en_q);
	c_swap: cover property (user_endian_swap_q);

endmodule : pcelc_core

// file: sim/pcelc_pipe_model.sv
// Pipeline model that presents one instruction slot at a time to the core
`timescale 1ns/1ps
module pcelc_pipe_model (
	// Clock
	input  wire logic clk_sys,
	// Slot strobe and attributes
	output logic        slot_valid,
	output logic        slot_compact,
	output logic        slot_branch_taken,
	output logic [31:0] slot_target,
	output logic        slot_link,
	output logic        slot_load_linked,
	output logic        slot_store_cond,
	output logic        slot_eret,
	output logic        slot_exception,
	output logic [31:0] slot_exc_vector,
	output logic        slot_late_wr,
	output logic [4:0]  slot_late_idx,
	output logic [31:0] slot_late_data
);
	// ==========================================================
	// Idle outputs at time zero
	initial begin
		slot_valid = 1'b0;
		{slot_late_wr, slot_exception, slot_eret, slot_store_cond} = 4'h0;
		{slot_load_linked, slot_link, slot_branch_taken, slot_compact} = 4'h0;
		{slot_target, slot_exc_vector, slot_late_data, slot_late_idx} = '0;
	end

	// One slot: kind bits select attributes, d carries target, vector and late data
	task automatic issue(input logic [7:0] k, input logic [31:0] d);
		@(posedge clk_sys);
		{slot_late_wr, slot_exception, slot_eret, slot_store_cond,
			slot_load_linked, slot_link, slot_branch_taken, slot_compact} <= k;
		{slot_target, slot_exc_vector, slot_late_data} <= {3{d}};
		slot_late_idx <= d[4:0];
		slot_valid    <= 1'b1;
		@(posedge clk_sys);
		// Outside a slot the fields carry junk, so the core must not look at them
		{slot_late_wr, slot_exception, slot_eret, slot_store_cond,
			slot_load_linked, slot_link, slot_branch_taken, slot_compact} <= ~k;
		{slot_target, slot_exc_vector, slot_late_data} <= {3{~d}};
		slot_late_idx <= ~d[4:0];
		slot_valid    <= 1'b0;
		#1;
	endtask : issue
endmodule : pcelc_pipe_model

// file: sim/test_pc_endian_link_reservation_flag_control.sv
// Self-checking bench for the endianness, reservation flag and PC sequencing core
`timescale 1ns/1ps
module test_pc_endian_link_reservation_flag_control import pcelc_pkg::*;;
	// ==========================================================
	// Signals
	logic              clk_sys, rstn, endian_strap_pin, avs_read, avs_write, avs_waitrequest;
	logic [ADDR_W-1:0] avs_address;
	logic [31:0]       avs_writedata, avs_readdata, slot_target, slot_exc_vector, slot_late_data, rd;
	logic [31:0]       pc_q, link_wr_data_q, epc_wr_data_q, late_wr_data_q;
	logic              slot_valid, slot_compact, slot_user_mode, slot_branch_taken, slot_link;
	logic              slot_load_linked, slot_store_cond, slot_eret, slot_exception, slot_late_wr;
	logic              atomic_conflict, instruction_set_select_q, memory_big_endian_cfg_q;
	logic              user_endian_swap_q, load_store_big_endian_q, link_reservation_flag_q;
	logic              sc_done_q, sc_success_q, link_wr_en_q, epc_wr_en_q, late_wr_en_q;
	logic [4:0]        slot_late_idx, link_wr_idx_q, late_wr_idx_q, compact_gpr_idx_q;
	logic [2:0]        slot_compact_reg;
	int                failures, samples_checked;
	localparam logic [7:0] K_CMP = 8'h01, K_BR = 8'h02, K_LNK = 8'h04, K_LL = 8'h08;
	localparam logic [7:0] K_SC = 8'h10, K_ERET = 8'h20, K_EXC = 8'h40, K_LW = 8'h80;

	pcelc_core u_dut (.*);
	pcelc_pipe_model u_pipe (.*);

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_of_test

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic do_reset(input logic strap);
		@(posedge clk_sys);
		rstn             <= 1'b0;
		endian_strap_pin <= strap;
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		tick(6);
	endtask : do_reset

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= ~wr;
		// Only the watchdog ends a wait that never ends
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		#1;
	endtask : bus

	// ==========================================================
	// Scenarios
	task automatic sc_reset();
		check("pc", pc_q, PC_RESET);
		check("llf", link_reservation_flag_q, 1'b0);
		check("mem_be", memory_big_endian_cfg_q, END_BIG);
		check("isa", instruction_set_select_q, ISA_WORD);
		bus(1'b0, 4'hC, 32'h0, rd);
		check("unmapped", rd, 32'h0);
	endtask : sc_reset

	task automatic sc_endian();
		bus(1'b1, REG_CTRL, 32'h0000_0001, rd);
		bus(1'b0, REG_CTRL, 32'h0, rd);
		check("re", rd[CTRL_RE_BIT], 1'b1);
		tick(3);
		check("swap_kernel", user_endian_swap_q, 1'b0);
		check("ls_be_kernel", load_store_big_endian_q, END_BIG);
		@(posedge clk_sys);
		slot_user_mode <= 1'b1;
		tick(3);
		check("swap_user", user_endian_swap_q, 1'b1);
		check("ls_be_user", load_store_big_endian_q, END_LITTLE);
		bus(1'b0, REG_STATE, 32'h0, rd);
		check("state", rd[2:0], 3'h5);
		do_reset(END_LITTLE);
		check("mem_be_lo", memory_big_endian_cfg_q, END_LITTLE);
		check("ls_be_lo", load_store_big_endian_q, END_LITTLE);
		bus(1'b1, REG_CTRL, 32'h0000_0001, rd);
		tick(3);
		check("ls_be_xor", load_store_big_endian_q, END_BIG);
		@(posedge clk_sys);
		slot_user_mode <= 1'b0;
	endtask : sc_endian

	task automatic sc_pc();
		u_pipe.issue(8'h00, 32'h0);
		check("pc_word", pc_q, 32'h0000_0004);
		u_pipe.issue(K_CMP, 32'h0);
		check("pc_compact", pc_q, 32'h0000_0006);
		u_pipe.issue(K_BR, 32'hF000_1000);
		check("pc_branch", pc_q, 32'h0000_000A);
		u_pipe.issue(8'h00, 32'h0);
		check("pc_target", pc_q, 32'hF000_1000);
		u_pipe.issue(K_BR | K_LNK, 32'h0000_2001);
		check("link_en", link_wr_en_q, 1'b1);
		check("link_idx", link_wr_idx_q, LINK_GPR);
		check("link_data", link_wr_data_q, 32'hF000_1008);
		check("pc_slot", pc_q, 32'hF000_1004);
		u_pipe.issue(K_EXC, 32'h8000_0180);
		check("epc_en", epc_wr_en_q, 1'b1);
		check("epc_data", epc_wr_data_q, 32'hF000_1004);
		check("isa_exc", instruction_set_select_q, ISA_WORD);
		u_pipe.issue(K_BR, 32'h0000_3001);
		u_pipe.issue(8'h00, 32'h0);
		check("isa_cmp", instruction_set_select_q, ISA_COMPACT);
		u_pipe.issue(K_LW, 32'h5A5A_0005);
		check("late_early", late_wr_en_q, 1'b0);
		u_pipe.issue(8'h00, 32'h0);
		check("late_en", late_wr_en_q, 1'b1);
		check("late_idx", late_wr_idx_q, 5'h05);
		check("late_data", late_wr_data_q, 32'h5A5A_0005);
	endtask : sc_pc

	task automatic sc_link_flag();
		u_pipe.issue(K_SC, 32'h0);
		check("sc_done", sc_done_q, 1'b1);
		check("sc_cold", sc_success_q, 1'b0);
		u_pipe.issue(K_LL, 32'h0);
		check("ll_set", link_reservation_flag_q, 1'b1);
		u_pipe.issue(K_SC, 32'h0);
		check("sc_ok", sc_success_q, 1'b1);
		check("sc_clr", link_reservation_flag_q, 1'b0);
		u_pipe.issue(K_LL, 32'h0);
		@(posedge clk_sys);
		atomic_conflict <= 1'b1;
		@(posedge clk_sys);
		atomic_conflict <= 1'b0;
		#1;
		check("conflict", link_reservation_flag_q, 1'b0);
		u_pipe.issue(K_LL, 32'h0);
		u_pipe.issue(K_ERET, 32'h0);
		check("eret", link_reservation_flag_q, 1'b0);
	endtask : sc_link_flag

	task automatic sc_xlat();
		for (int v = 0; v < 8; v++) begin
			@(posedge clk_sys);
			slot_compact_reg <= v[2:0];
			tick(2);
			check("xlat", compact_gpr_idx_q, v == 0 ? XLAT_R0 : v == 1 ? XLAT_R1 : {2'h0, v[2:0]});
		end
	endtask : sc_xlat

	// ==========================================================
	// Main sequence
	initial begin
		{rstn, avs_read, avs_write, slot_user_mode, atomic_conflict} = 5'h00;
		endian_strap_pin = END_BIG;
		avs_address      = '0;
		avs_writedata    = 32'h0;
		slot_compact_reg = 3'h0;
		failures         = 0;
		samples_checked  = 0;
		do_reset(END_BIG);
		sc_reset();
		sc_endian();
		sc_pc();
		sc_link_flag();
		sc_xlat();
		end_of_test();
	end

	// Watchdog against a hung handshake
	initial begin
		#100000;
		failures++;
		end_of_test();
	end
endmodule : test_pc_endian_link_reservation_flag_control
